// ==== inc/scsd_cfg.svh ====
// Register map, field positions and reset values of the clock select block
// Behaviour
// R1 - Pin select routes pins main or sub
// R2 - Wait gate stops peripheral clock in wait
// R3 - Sub pin enable: set by write, never cleared
// R4 - Main stop halts only on on-chip source
// R5 - External main clock input stays accepted
// R6 - Software clears detect bits before main stop
// R7 - Pins are I/O only with all four settings; code also requires the on-chip source
// R8 - Stop entry forces divide-by-8 select
// R9 - Div8 select one divides source by eight
// R10 - Divider field: 1, 2, 4, 16
// R11 - Crystal select: main when 0, sub when 1
// R12 - Software selects sub only after it stabilises
// R13 - All-clock stop writes enter stop mode
// R14 - Stop mode disables feedback resistors
// R15 - Feedback resistor bits: 0 enable, 1 disable
// R16 - Main pin enable: 0 ports, 1 crystal
// R17 - Low-speed stop forced 0 under on-chip source
// R18 - Software keeps low-speed osc for monitors
// R19 - No stop while detector low consumption
// R20 - No stop with exit select 00b on-chip
// R21 - Software unlocks before rewriting clock registers
// R22 - Locked writes to clock registers ignored
// R23 - Software writes reserved bits as documented
`ifndef SCSD_CFG_SVH
`define SCSD_CFG_SVH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define SCSD_IDX_CTRL0      6'h06
`define SCSD_IDX_CTRL1      6'h07
`define SCSD_IDX_PROTECT    6'h0A
`define SCSD_IDX_SRCSEL     6'h0B
`define SCSD_IDX_STATUS     6'h0C

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCSD_RST_CTRL0      8'h28
`define SCSD_RST_CTRL1      8'h20
`define SCSD_RST_PROTECT    8'h00
`define SCSD_RST_SRCSEL     8'h00

// ----------------------------------------------------------------
// Field positions, control register 0
// ----------------------------------------------------------------
`define SCSD_B_MAIN_SUB_PIN 1
`define SCSD_B_WAIT_GATE    2
`define SCSD_B_SUB_STOP     3
`define SCSD_B_SUB_PIN_EN   4
`define SCSD_B_MAIN_STOP    5
`define SCSD_B_DIV8_SEL     6
`define SCSD_B_XTAL_SEL     7

// ----------------------------------------------------------------
// Field positions, control register 1 and own registers
// ----------------------------------------------------------------
`define SCSD_B_ALL_STOP     0
`define SCSD_B_MAIN_FB_DIS  1
`define SCSD_B_SUB_FB_DIS   2
`define SCSD_B_MAIN_PIN_EN  3
`define SCSD_B_LSO_STOP     4
`define SCSD_B_DIV_LO       6
`define SCSD_B_DIV_HI       7
`define SCSD_B_UNLOCK       0
`define SCSD_B_DET_EN       0
`define SCSD_B_DET_IRQ_EN   1
`define SCSD_B_SYS_SRC      2

`endif

// ==== inc/scsd_pkg.sv ====
// Types shared by the clock select block
package scsd_pkg;

    // Power state, Gray coded along run, wait, stop
    typedef enum logic [1:0] {
        SCSD_RUN  = 2'b00,
        SCSD_WAIT = 2'b01,
        SCSD_STOP = 2'b11
    } scsd_pwr_e;

    typedef logic [3:0] scsd_cnt_t;

endpackage : scsd_pkg

// ==== rtl/scsd_top.sv ====
// System clock select and divide control with its register slave
`timescale 1ns/1ns
`include "scsd_cfg.svh"

module scsd_top #(
    parameter int AW = 6
) (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // Wishbone classic slave
    input  wire logic          cyc_i,
    input  wire logic          stb_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] adr_i,
    input  wire logic [3:0]    sel_i,
    input  wire logic [31:0]   dat_i,
    output logic      [31:0]   dat_o,
    output logic               ack_o,
    // Processor state
    input  wire logic          wait_mode_i,
    input  wire logic          wake_i,
    // Clock tree controls
    output logic               cpu_clk_en_o,
    output logic               periph_clk_en_o,
    output logic               xtal_sub_sel_o,
    output logic               onchip_src_sel_o,
    output logic               stop_mode_o,
    // Oscillator controls
    output logic               main_osc_en_o,
    output logic               main_ext_in_en_o,
    output logic               sub_osc_en_o,
    output logic               low_speed_osc_en_o,
    output logic               main_fb_res_en_o,
    output logic               sub_fb_res_en_o,
    // Shared pin routing
    output logic               shared_pin_io_o,
    output logic               shared_pin_main_o,
    output logic               shared_pin_sub_o
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0]              ctrl0;
    logic [7:0]              ctrl1;
    logic [7:0]              protect_register;
    logic [7:0]              srcsel;
    logic [7:0]              next_ctrl0;
    logic [7:0]              next_ctrl1;
    logic [7:0]              next_protect;
    logic [7:0]              next_srcsel;
    logic                    ack;
    logic [31:0]             rdata;
    logic                    next_ack;
    logic [31:0]             next_rdata;
    scsd_pkg::scsd_pwr_e     pwr;
    scsd_pkg::scsd_pwr_e     next_pwr;
    scsd_pkg::scsd_cnt_t     div_cnt;
    scsd_pkg::scsd_cnt_t     next_div_cnt;
    scsd_pkg::scsd_cnt_t     div_max;

    logic req;
    logic wr;
    logic unlocked;
    logic tick;

    assign req      = cyc_i && stb_i && !ack;
    assign wr       = req && we_i && sel_i[0];
    assign unlocked = protect_register[`SCSD_B_UNLOCK];

    // Address decode, used by both the write and the read path
    function automatic logic hit(input logic [AW-1:0] a, input logic [5:0] idx);
        hit = (a == AW'(idx));
    endfunction : hit

    // Divider reload for the selected ratio, value is ratio minus one
    function automatic scsd_pkg::scsd_cnt_t ratio_max(input logic d8, input logic [1:0] f);
        if (d8) begin
            ratio_max = 4'h7; // see R9
        end else begin
            case (f) // see R10
                2'b00:   ratio_max = 4'h0;
                2'b01:   ratio_max = 4'h1;
                2'b10:   ratio_max = 4'h3;
                default: ratio_max = 4'hF;
            endcase
        end
    endfunction : ratio_max

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_comb begin
        next_ctrl0   = ctrl0;
        next_ctrl1   = ctrl1;
        next_protect = protect_register;
        next_srcsel  = srcsel;
        if (wr) begin
            // Protect register itself is always writable
            if (hit(adr_i, `SCSD_IDX_PROTECT)) begin
                next_protect = dat_i[7:0];
            end else if (hit(adr_i, `SCSD_IDX_CTRL0) && unlocked) begin // see R22
                next_ctrl0 = dat_i[7:0];
                // Sticky once set
                next_ctrl0[`SCSD_B_SUB_PIN_EN] = dat_i[`SCSD_B_SUB_PIN_EN]
                    || ctrl0[`SCSD_B_SUB_PIN_EN]; // see R3
            end else if (hit(adr_i, `SCSD_IDX_CTRL1) && unlocked) begin // see R22
                next_ctrl1 = dat_i[7:0]; // see R13
            end else if (hit(adr_i, `SCSD_IDX_SRCSEL) && unlocked) begin
                next_srcsel = {5'h00, dat_i[2:0]};
            end
        end
        // Wake from stop clears the stop request
        if (wake_i && ctrl1[`SCSD_B_ALL_STOP]) begin
            next_ctrl1[`SCSD_B_ALL_STOP] = 1'b0;
        end
        // Stop entry forces the divide-by-8 ratio for the restart
        if (next_ctrl1[`SCSD_B_ALL_STOP] && !ctrl1[`SCSD_B_ALL_STOP]) begin
            next_ctrl0[`SCSD_B_DIV8_SEL] = 1'b1; // see R8
        end
        // On-chip source keeps the low-speed oscillator running except in stop mode
        if (next_srcsel[`SCSD_B_SYS_SRC]) begin
            next_ctrl1[`SCSD_B_LSO_STOP] = 1'b0; // see R17
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl0            <= `SCSD_RST_CTRL0;
            ctrl1            <= `SCSD_RST_CTRL1;
            protect_register <= `SCSD_RST_PROTECT;
            srcsel           <= `SCSD_RST_SRCSEL;
        end else begin
            ctrl0            <= next_ctrl0;
            ctrl1            <= next_ctrl1;
            protect_register <= next_protect;
            srcsel           <= next_srcsel;
        end
    end

    // ----------------------------------------------------------------
    // Bus answer
    // ----------------------------------------------------------------
    // One wait state; unmapped reads return zero, writes there drop
    always_comb begin
        next_ack   = req;
        next_rdata = 32'h0000_0000;
        if (req && !we_i) begin
            if (hit(adr_i, `SCSD_IDX_CTRL0)) begin
                next_rdata = {24'h00_0000, ctrl0};
            end else if (hit(adr_i, `SCSD_IDX_CTRL1)) begin
                next_rdata = {24'h00_0000, ctrl1};
            end else if (hit(adr_i, `SCSD_IDX_PROTECT)) begin
                next_rdata = {24'h00_0000, protect_register};
            end else if (hit(adr_i, `SCSD_IDX_SRCSEL)) begin
                next_rdata = {24'h00_0000, srcsel};
            end else if (hit(adr_i, `SCSD_IDX_STATUS)) begin
                next_rdata = {24'h00_0000, div_max, shared_pin_io_o,
                              main_osc_en_o, pwr};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack   <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            ack   <= next_ack;
            rdata <= next_rdata;
        end
    end

    assign ack_o = ack;
    assign dat_o = rdata;

    // ----------------------------------------------------------------
    // Power state
    // ----------------------------------------------------------------
    always_comb begin
        next_pwr = pwr;
        case (pwr)
            scsd_pkg::SCSD_RUN: begin
                if (ctrl1[`SCSD_B_ALL_STOP]) begin
                    next_pwr = scsd_pkg::SCSD_STOP; // see R13
                end else if (wait_mode_i) begin
                    next_pwr = scsd_pkg::SCSD_WAIT;
                end
            end
            scsd_pkg::SCSD_WAIT: begin
                if (ctrl1[`SCSD_B_ALL_STOP]) begin
                    next_pwr = scsd_pkg::SCSD_STOP;
                end else if (!wait_mode_i) begin
                    next_pwr = scsd_pkg::SCSD_RUN;
                end
            end
            scsd_pkg::SCSD_STOP: begin
                if (!ctrl1[`SCSD_B_ALL_STOP]) begin
                    next_pwr = scsd_pkg::SCSD_RUN;
                end
            end
            default: next_pwr = scsd_pkg::SCSD_RUN;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr <= scsd_pkg::SCSD_RUN;
        end else begin
            pwr <= next_pwr;
        end
    end

    // ----------------------------------------------------------------
    // CPU clock divider
    // ----------------------------------------------------------------
    // Reload only at the tick, so a ratio change never gives a runt
    assign div_max = ratio_max(ctrl0[`SCSD_B_DIV8_SEL],
                               ctrl1[`SCSD_B_DIV_HI:`SCSD_B_DIV_LO]);
    assign tick    = (div_cnt == 4'h0);

    always_comb begin
        next_div_cnt = tick ? div_max : div_cnt - 4'h1; // see R9
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt <= 4'h0;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

    assign cpu_clk_en_o = tick && (pwr == scsd_pkg::SCSD_RUN);

    // ----------------------------------------------------------------
    // Clock tree and oscillator controls
    // ----------------------------------------------------------------
    assign stop_mode_o      = ctrl1[`SCSD_B_ALL_STOP]; // see R13
    assign xtal_sub_sel_o   = ctrl0[`SCSD_B_XTAL_SEL]; // see R11
    assign onchip_src_sel_o = srcsel[`SCSD_B_SYS_SRC];
    assign periph_clk_en_o  = !stop_mode_o
        && !(wait_mode_i && ctrl0[`SCSD_B_WAIT_GATE]); // see R2

    // Main stop bit acts only while the on-chip source is in use
    assign main_osc_en_o = !stop_mode_o
        && !(ctrl0[`SCSD_B_MAIN_STOP] && srcsel[`SCSD_B_SYS_SRC]); // see R4
    // External input path is never closed by the stop bit
    assign main_ext_in_en_o = ctrl1[`SCSD_B_MAIN_PIN_EN]; // see R5
    assign sub_osc_en_o = !stop_mode_o && ctrl0[`SCSD_B_SUB_PIN_EN]
        && !ctrl0[`SCSD_B_SUB_STOP];
    assign low_speed_osc_en_o = !stop_mode_o && !ctrl1[`SCSD_B_LSO_STOP];
    assign main_fb_res_en_o = !stop_mode_o
        && !ctrl1[`SCSD_B_MAIN_FB_DIS]; // see R14 see R15
    assign sub_fb_res_en_o = !stop_mode_o
        && !ctrl1[`SCSD_B_SUB_FB_DIS]; // see R14 see R15

    // ----------------------------------------------------------------
    // Shared pin routing
    // ----------------------------------------------------------------
    // Ports need the on-chip source too, else the main stop bit is
    // ignored and the main oscillator would still drive the pins
    assign shared_pin_io_o = !ctrl1[`SCSD_B_MAIN_PIN_EN]
        && ctrl0[`SCSD_B_MAIN_STOP] && !ctrl0[`SCSD_B_SUB_PIN_EN]
        && ctrl0[`SCSD_B_SUB_STOP] && srcsel[`SCSD_B_SYS_SRC]; // see R7
    assign shared_pin_main_o = ctrl1[`SCSD_B_MAIN_PIN_EN]
        && !ctrl0[`SCSD_B_MAIN_SUB_PIN]; // see R1 see R16
    assign shared_pin_sub_o = ctrl0[`SCSD_B_SUB_PIN_EN]
        && ctrl0[`SCSD_B_MAIN_SUB_PIN]; // see R1

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_idle7;
        !tick [*7];
    endsequence

    sequence s_idle3;
        !tick [*3];
    endsequence

    chk_sub_pin_sticky: assert property ( // see R3
        ctrl0[`SCSD_B_SUB_PIN_EN] |=> ctrl0[`SCSD_B_SUB_PIN_EN])
        else $error("subclock pin enable was cleared");

    chk_locked_write: assert property ( // see R22
        (wr && !unlocked && hit(adr_i, `SCSD_IDX_CTRL0)
         && !wake_i) |=> $stable(ctrl0))
        else $error("locked write changed control 0");

    chk_stop_div8: assert property ( // see R8
        $rose(ctrl1[`SCSD_B_ALL_STOP]) |-> ctrl0[`SCSD_B_DIV8_SEL])
        else $error("stop entry did not set divide by 8");

    chk_div8_period: assert property ( // see R9
        (tick && div_max == 4'h7 && !rst_i) |=> s_idle7 ##1 tick)
        else $error("divide by 8 period wrong");

    chk_div4_period: assert property ( // see R10
        (tick && div_max == 4'h3) |=> s_idle3 ##1 tick)
        else $error("divide by 4 period wrong");

    chk_lso_forced: assert property ( // see R17
        srcsel[`SCSD_B_SYS_SRC] |-> !ctrl1[`SCSD_B_LSO_STOP])
        else $error("low speed stop set under on-chip source");

    chk_main_halt: assert property ( // see R4
        (!main_osc_en_o && !stop_mode_o) |-> srcsel[`SCSD_B_SYS_SRC])
        else $error("main oscillator halted on crystal source");

    chk_periph_gate: assert property ( // see R2
        (wait_mode_i && ctrl0[`SCSD_B_WAIT_GATE]) |-> !periph_clk_en_o)
        else $error("peripheral clock ran in gated wait");

    chk_stop_fb: assert property ( // see R14
        stop_mode_o |-> !main_fb_res_en_o && !sub_fb_res_en_o)
        else $error("feedback resistor on in stop mode");

    chk_pin_io: assert property ( // see R7
        shared_pin_io_o |-> !main_osc_en_o && !sub_osc_en_o)
        else $error("pins released while oscillators in use");

    chk_ack_pulse: assert property (
        ack |=> !ack)
        else $error("ack longer than one cycle");

endmodule : scsd_top

// ==== tb/scsd_top_tb_top.sv ====
// Self-checking bench for the clock select and divide block
`timescale 1ns/1ns
`include "scsd_cfg.svh"

module scsd_top_tb_top;

    typedef struct packed {
        logic [5:0] idx;
        logic [7:0] wd;
        logic [7:0] rd;
        logic       wm;
    } scsd_row_s;

    localparam logic [5:0] C0 = `SCSD_IDX_CTRL0;
    localparam logic [5:0] C1 = `SCSD_IDX_CTRL1;
    localparam logic [5:0] SR = `SCSD_IDX_SRCSEL;

    logic        clk_i = 1'b0;
    logic        rst_i;
    logic        cyc, stb, we, wait_mode, wake;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, dat_o;
    logic        ack_o, cpu_clk_en_o, periph_clk_en_o, xtal_sub_sel_o, onchip_src_sel_o;
    logic        stop_mode_o, main_osc_en_o, main_ext_in_en_o, sub_osc_en_o;
    logic        low_speed_osc_en_o, main_fb_res_en_o, sub_fb_res_en_o;
    logic        shared_pin_io_o, shared_pin_main_o, shared_pin_sub_o;
    logic [7:0]  c0, c1, src, rd;
    int          fail_count = 0;
    int          num_checks = 0;
    scsd_row_s   rows [17];

    always #2 clk_i = ~clk_i;

    scsd_top #(.AW(6)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
        .wait_mode_i(wait_mode), .wake_i(wake), .cpu_clk_en_o(cpu_clk_en_o),
        .periph_clk_en_o(periph_clk_en_o), .xtal_sub_sel_o(xtal_sub_sel_o),
        .onchip_src_sel_o(onchip_src_sel_o), .stop_mode_o(stop_mode_o),
        .main_osc_en_o(main_osc_en_o), .main_ext_in_en_o(main_ext_in_en_o),
        .sub_osc_en_o(sub_osc_en_o), .low_speed_osc_en_o(low_speed_osc_en_o),
        .main_fb_res_en_o(main_fb_res_en_o), .sub_fb_res_en_o(sub_fb_res_en_o),
        .shared_pin_io_o(shared_pin_io_o), .shared_pin_main_o(shared_pin_main_o),
        .shared_pin_sub_o(shared_pin_sub_o)
    );

    // ----------------------------------------------------------------
    // Reporting
    // ----------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // ----------------------------------------------------------------
    // Bus and measurement helpers, entered just after a rising edge
    // ----------------------------------------------------------------
    task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d,
                      output logic [7:0] r);
        int n;
        n = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'hF;
        wdat <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            conclude();
        end
        r = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    // Third gap is measured so a pending reload has surely landed
    task automatic div_check(input int exp);
        int n;
        int k;
        for (k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (cpu_clk_en_o !== 1'b1 && n < 64);
            if (n >= 64) begin
                fail_count++;
                conclude();
            end
        end
        check(n, exp);
    endtask : div_check

    function automatic int exp_div(input logic [7:0] a, input logic [7:0] b);
        if (a[6]) return 8;
        case (b[7:6])
            2'b00: return 1;
            2'b01: return 2;
            2'b10: return 4;
            default: return 16;
        endcase
    endfunction : exp_div

    function automatic logic [10:0] exp_out(input logic [7:0] a, input logic [7:0] b,
                                            input logic [7:0] s, input logic wm);
        logic stp;
        logic io;
        stp = b[0];
        io  = !b[3] & a[5] & !a[4] & a[3] & s[2];
        return {a[7], s[2], stp, !(stp | (a[5] & s[2])), b[3], a[4] & !a[3] & !stp,
                !stp & !b[4], !stp & !b[1], !stp & !b[2], io, !(stp | (wm & a[2]))};
    endfunction : exp_out

    task automatic check_outs();
        check({xtal_sub_sel_o, onchip_src_sel_o, stop_mode_o, main_osc_en_o,
               main_ext_in_en_o, sub_osc_en_o, low_speed_osc_en_o, main_fb_res_en_o,
               sub_fb_res_en_o, shared_pin_io_o, periph_clk_en_o},
              exp_out(c0, c1, src, wait_mode));
        // A crystal owns the pins only when its own pin enable is set
        check({shared_pin_main_o, shared_pin_sub_o},
              {c1[3] & !c0[1], c0[4] & c0[1]});
    endtask : check_outs

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 6'h00; sel = 4'h0;
        wdat = 32'h00000000; wait_mode = 1'b0; wake = 1'b0;
        rows = '{'{C0, 8'h06, 8'h06, 1'b1}, '{C0, 8'h02, 8'h02, 1'b1},
                 '{C0, 8'h28, 8'h28, 1'b0}, '{C1, 8'h3E, 8'h3E, 1'b0},
                 '{C1, 8'hA0, 8'hA0, 1'b0}, '{C1, 8'h60, 8'h60, 1'b0},
                 '{C1, 8'hE0, 8'hE0, 1'b0}, '{C1, 8'h30, 8'h30, 1'b0},
                 '{SR, 8'h04, 8'h04, 1'b0}, '{C1, 8'h30, 8'h20, 1'b0},
                 '{SR, 8'h00, 8'h00, 1'b0}, '{C0, 8'h10, 8'h10, 1'b0},
                 '{C0, 8'h28, 8'h38, 1'b0}, '{C0, 8'hAA, 8'hBA, 1'b0},
                 '{C0, 8'h68, 8'h78, 1'b0}, '{C0, 8'h3A, 8'h3A, 1'b0},
                 '{6'h3F, 8'hFF, 8'h00, 1'b0}};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        c0 = 8'h28; c1 = 8'h20; src = 8'h00;
        wb(1'b0, C0, 8'h00, rd);
        check(rd, c0);
        wb(1'b0, C1, 8'h00, rd);
        check(rd, c1);
        check_outs();
        div_check(1);
        wb(1'b1, C0, 8'hFF, rd);
        wb(1'b0, C0, 8'h00, rd);
        check(rd, c0);
        $display("test reset and lock done");

        wb(1'b1, `SCSD_IDX_PROTECT, 8'h01, rd);
        foreach (rows[i]) begin
            wait_mode <= rows[i].wm;
            wb(1'b1, rows[i].idx, rows[i].wd, rd);
            wb(1'b0, rows[i].idx, 8'h00, rd);
            check(rd, rows[i].rd);
            if (rows[i].idx == C0) c0 = rows[i].rd;
            if (rows[i].idx == C1) c1 = rows[i].rd;
            if (rows[i].idx == SR) src = rows[i].rd;
            if (src[2]) c1[4] = 1'b0;
            check_outs();
            if (!rows[i].wm) div_check(exp_div(c0, c1));
        end
        wait_mode <= 1'b0;
        $display("test register rows done");

        // Stop entry forces divide-by-8 and drops every oscillator
        wb(1'b1, C1, 8'h21, rd);
        c1 = 8'h21;
        c0 = c0 | 8'h40;
        wb(1'b0, C0, 8'h00, rd);
        check(rd, c0);
        check_outs();
        check(cpu_clk_en_o, 1'b0);
        wb(1'b0, `SCSD_IDX_STATUS, 8'h00, rd);
        check(rd, 8'h73);
        wake <= 1'b1;
        @(posedge clk_i);
        wake <= 1'b0;
        @(posedge clk_i);
        c1 = 8'h20;
        wb(1'b0, C1, 8'h00, rd);
        check(rd, c1);
        check_outs();
        div_check(8);
        $display("test stop and wake done");

        wb(1'b1, `SCSD_IDX_PROTECT, 8'h00, rd);
        wb(1'b1, C1, 8'hE0, rd);
        wb(1'b1, C0, 8'h00, rd);
        wb(1'b0, C1, 8'h00, rd);
        check(rd, c1);
        wb(1'b0, C0, 8'h00, rd);
        check(rd, c0);
        $display("test relock done");

        // Mid-run reset restores every register and relocks the bus
        rst_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        c0 = `SCSD_RST_CTRL0;
        c1 = `SCSD_RST_CTRL1;
        src = `SCSD_RST_SRCSEL;
        wb(1'b0, C0, 8'h00, rd);
        check(rd, c0);
        wb(1'b0, C1, 8'h00, rd);
        check(rd, c1);
        wb(1'b1, C1, 8'hE0, rd);
        wb(1'b0, C1, 8'h00, rd);
        check(rd, c1);
        wb(1'b0, `SCSD_IDX_STATUS, 8'h00, rd);
        check(rd, 8'h04);
        check_outs();
        div_check(1);
        $display("test mid-run reset done");
        conclude();
    end

endmodule : scsd_top_tb_top
